// file: rtl/cfg_hdr_defs.svh
// Constants for the configuration bytes 09h to 0Dh and the master tenure timer
`ifndef CFG_HDR_DEFS_SVH
`define CFG_HDR_DEFS_SVH

// Configuration dword numbers, matched against byte address bits 7:2, low two bits ignored
`define CFG_DW_CLASS      6'h02
`define CFG_DW_LINE       6'h03

// Byte offsets of the fields held by this block
`define CFG_OFF_PROG_IF   8'h09
`define CFG_OFF_SUB_CLASS 8'h0A
`define CFG_OFF_BASE      8'h0B
`define CFG_OFF_LINE_SIZE 8'h0C
`define CFG_OFF_TENURE    8'h0D

// Byte lane of the tenure timer inside dword 0Ch
`define CFG_LANE_TENURE   1

// Reset values
`define LINE_SIZE_RESET   8'h00
`define TENURE_RESET      8'h00
`define CLASS_RESET       24'hFF0000

// Tenure timer field split: bits 7:3 writable, bits 2:0 read as zero
`define TENURE_WR_MSB     7
`define TENURE_WR_LSB     3
`define TENURE_RO_ZERO    3'h0

// Bus commands
`define CMD_MEM_WRITE     4'h7
`define CMD_MEM_WR_INV    4'hF

// Counter steps
`define TENURE_ZERO       8'h00
`define TENURE_STEP       8'h01

`endif

// file: rtl/cfg_hdr_pkg.sv
// Types shared by the configuration header byte block
package cfg_hdr_pkg;

  // Tenure timer phases of one master transaction
  typedef enum logic [1:0] {
    TEN_IDLE,
    TEN_RUN,
    TEN_EXPIRED
  } tenure_state_t;

  // One class code, laid out as it sits at bytes 0Bh..09h
  typedef struct packed {
    logic [7:0] base;
    logic [7:0] sub;
    logic [7:0] prog_if;
  } class_code_t;

endpackage : cfg_hdr_pkg

// file: rtl/class_code_check.sv
// Checks a class code against the table of defined base and sub-class encodings
`timescale 1ns/100ps
`default_nettype none

module class_code_check
  import cfg_hdr_pkg::*;
(
  input  wire logic [23:0] code_i,   // Candidate {base, sub, prog_if}
  output logic             legal_o   // Candidate is a defined encoding
);

  // Entry: {base, sub, highest prog_if, any prog_if allowed}
  localparam int N_ENT = 54;
  localparam logic [24:0] TABLE [N_ENT] = '{
    // Early devices
    {8'h00, 8'h00, 8'h00, 1'b0}, {8'h00, 8'h01, 8'h00, 1'b0},
    // Mass storage, IDE takes any interface byte (see [R9])
    {8'h01, 8'h00, 8'h00, 1'b0}, {8'h01, 8'h01, 8'h00, 1'b1},
    {8'h01, 8'h02, 8'h00, 1'b0}, {8'h01, 8'h03, 8'h00, 1'b0},
    {8'h01, 8'h04, 8'h00, 1'b0}, {8'h01, 8'h80, 8'h00, 1'b0},
    // Network (see [R10])
    {8'h02, 8'h00, 8'h00, 1'b0}, {8'h02, 8'h01, 8'h00, 1'b0},
    {8'h02, 8'h02, 8'h00, 1'b0}, {8'h02, 8'h03, 8'h00, 1'b0},
    {8'h02, 8'h80, 8'h00, 1'b0},
    // Display (see [R11])
    {8'h03, 8'h00, 8'h01, 1'b0}, {8'h03, 8'h01, 8'h00, 1'b0},
    {8'h03, 8'h80, 8'h00, 1'b0},
    // Multimedia and memory (see [R12])
    {8'h04, 8'h00, 8'h00, 1'b0}, {8'h04, 8'h01, 8'h00, 1'b0},
    {8'h04, 8'h80, 8'h00, 1'b0}, {8'h05, 8'h00, 8'h00, 1'b0},
    {8'h05, 8'h01, 8'h00, 1'b0}, {8'h05, 8'h80, 8'h00, 1'b0},
    // Bridges (see [R13])
    {8'h06, 8'h00, 8'h00, 1'b0}, {8'h06, 8'h01, 8'h00, 1'b0},
    {8'h06, 8'h02, 8'h00, 1'b0}, {8'h06, 8'h03, 8'h00, 1'b0},
    {8'h06, 8'h04, 8'h00, 1'b0}, {8'h06, 8'h05, 8'h00, 1'b0},
    {8'h06, 8'h06, 8'h00, 1'b0}, {8'h06, 8'h07, 8'h00, 1'b0},
    {8'h06, 8'h80, 8'h00, 1'b0},
    // Simple communications (see [R14])
    {8'h07, 8'h00, 8'h02, 1'b0}, {8'h07, 8'h01, 8'h02, 1'b0},
    {8'h07, 8'h80, 8'h00, 1'b0},
    // System peripherals (see [R15])
    {8'h08, 8'h00, 8'h02, 1'b0}, {8'h08, 8'h01, 8'h02, 1'b0},
    {8'h08, 8'h02, 8'h02, 1'b0}, {8'h08, 8'h03, 8'h01, 1'b0},
    {8'h08, 8'h80, 8'h00, 1'b0},
    // Input and docking (see [R16])
    {8'h09, 8'h00, 8'h00, 1'b0}, {8'h09, 8'h01, 8'h00, 1'b0},
    {8'h09, 8'h02, 8'h00, 1'b0}, {8'h09, 8'h80, 8'h00, 1'b0},
    {8'h0A, 8'h00, 8'h00, 1'b0}, {8'h0A, 8'h80, 8'h00, 1'b0},
    // Processors (see [R17])
    {8'h0B, 8'h00, 8'h00, 1'b0}, {8'h0B, 8'h01, 8'h00, 1'b0},
    {8'h0B, 8'h02, 8'h00, 1'b0}, {8'h0B, 8'h10, 8'h00, 1'b0},
    {8'h0B, 8'h40, 8'h00, 1'b0},
    // Serial buses (see [R18])
    {8'h0C, 8'h00, 8'h00, 1'b0}, {8'h0C, 8'h01, 8'h00, 1'b0},
    {8'h0C, 8'h02, 8'h00, 1'b0},
    // Unclassified device
    {8'hFF, 8'h00, 8'h00, 1'b0}
  };

  class_code_t      code;      // Candidate split into fields
  logic [N_ENT-1:0] hit;       // One match flag per table entry

  assign code = class_code_t'(code_i);

  // Each entry matches base and sub exactly and bounds the interface byte unless its any flag is set
  for (genvar i = 0; i < N_ENT; i++)
  begin : g_ent
    assign hit[i] = (code.base == TABLE[i][24:17]) && (code.sub == TABLE[i][16:9]) &&
                    (TABLE[i][0] || (code.prog_if <= TABLE[i][8:1]));
  end

  assign legal_o = |hit;

endmodule : class_code_check

`default_nettype wire

// file: rtl/pci_cfg_latency_class_codes.sv
// Configuration bytes 09h..0Dh: class code, line size byte, master tenure timer
//
// Overview of operation
// [R1] Line size byte reads zero, ignores writes, never loaded
// [R2] Master never issues memory write and invalidate
// [R3] Target never cuts bursts at line boundaries
// [R4] Tenure timer: bits 7:3 writable, 2:0 zero
// [R5] Tenure timer resets zero, optional load from 04Dh
// [R6] Nonzero count decrements per clock after grant, frame
// [R7] Count above zero: keep transferring without grant
// [R8] Count zero, grant gone: finish phase, release bus
// [R9] Mass storage sub-class encodings
// [R10] Network sub-class encodings, interface zero
// [R11] Display sub-class and interface encodings
// [R12] Multimedia and memory controller encodings
// [R13] Bridge sub-class encodings 00h..07h, 80h
// [R14] Serial and parallel port encodings
// [R15] System peripheral encodings and interfaces
// [R16] Input device and docking station encodings
// [R17] Processor sub-class encodings
// [R18] Serial bus controller encodings
// [R19] Class code bytes 09h..0Bh, base defaults FFh
`timescale 1ns/100ps
`default_nettype none
`include "cfg_hdr_defs.svh"

module pci_cfg_latency_class_codes
  import cfg_hdr_pkg::*;
(
  input  wire logic        core_clk_i,      // PCI clock domain, 250 MHz
  input  wire logic        rstn_i,          // Asynchronous reset, active low
  // Configuration cycle access, one dword per request
  input  wire logic        cfg_rd_i,        // Configuration read strobe
  input  wire logic        cfg_wr_i,        // Configuration write strobe
  input  wire logic [7:0]  cfg_addr_i,      // Byte address, low bits ignored
  input  wire logic [3:0]  cfg_be_i,        // Byte enables, active high
  input  wire logic [31:0] cfg_wdata_i,     // Write data
  output logic [31:0]      cfg_rdata_o,     // Read data, registered
  output logic             cfg_ack_o,       // One-cycle answer to a request
  // Boot load from the non-volatile loader, same clock
  input  wire logic        nv_load_i,       // Pulse: loaded bytes are present
  input  wire logic        nv_valid_i,      // Loaded image passed its check
  input  wire logic [7:0]  nv_tenure_i,     // Byte from offset 04Dh
  input  wire logic [23:0] nv_class_i,      // Bytes from offsets 049h..04Bh
  // Master side
  input  wire logic        gnt_n_i,         // Bus grant pin, active low
  input  wire logic        mst_frame_i,     // Our master drives FRAME#
  input  wire logic        mst_data_ok_i,   // A data phase may end now
  input  wire logic [3:0]  mst_cmd_i,       // Command from the master engine
  output logic [3:0]       mst_cmd_o,       // Command placed on the bus
  output logic             mst_stop_o,      // Master must end its tenure
  output logic             tenure_live_o,   // Tenure count still above zero
  // Target side
  output logic             tgt_line_disc_o, // Disconnect at a line boundary
  // Observed register contents
  output logic [7:0]       tenure_o,        // Programmed tenure value
  output logic [23:0]      class_o,         // Reported class code
  output logic             class_rej_o      // Boot-loaded class was refused
);

  // Grant synchroniser: first stage feeds only the second
  logic gnt_meta_q;                 // First stage
  logic gnt_n_q;                    // Second stage, safe to use

  // Registers
  logic [7:0]    tenure_q;          // Programmed tenure value
  logic [7:0]    tenure_d;
  logic [23:0]   class_q;           // Class code bytes
  logic [23:0]   class_d;
  logic          class_rej_q;       // Last boot load held an undefined code
  logic          class_rej_d;
  logic [7:0]    count_q;           // Running tenure count
  logic [7:0]    count_d;
  tenure_state_t state_q;           // Tenure phase
  tenure_state_t state_d;
  logic          frame_q;           // Frame seen last cycle
  logic          stop_q;            // Registered stop request
  logic          stop_d;
  logic [3:0]    cmd_q;             // Registered bus command
  logic [3:0]    cmd_d;
  logic [31:0]   rdata_q;           // Registered read data
  logic [31:0]   rdata_d;
  logic          ack_q;             // Registered answer
  logic          live_q;            // Tenure count above zero, registered
  logic          live_d;
  logic          line_disc_q;       // Never set: no line tracking

  // Decode
  wire [5:0] dw_sel      = cfg_addr_i[7:2];
  wire       hit_class   = (dw_sel == `CFG_DW_CLASS);
  wire       hit_line    = (dw_sel == `CFG_DW_LINE);
  wire       wr_tenure   = cfg_wr_i && hit_line && cfg_be_i[`CFG_LANE_TENURE];
  wire       boot_ok     = nv_load_i && nv_valid_i;
  wire       class_legal;           // Boot class is a defined encoding
  wire       frame_start = mst_frame_i && !frame_q && !gnt_n_q;
  wire       granted     = !gnt_n_q;
  wire       count_zero  = (count_q == `TENURE_ZERO);

  // Table lookup for a boot-loaded class code
  class_code_check u_class_check (
    .code_i  (nv_class_i),
    .legal_o (class_legal)
  );

  // Tenure register: host write has priority over a late boot load
  always_comb
  begin
    tenure_d = tenure_q;
    if (wr_tenure)
    begin
      // Only bits 7:3 take the write (see [R4])
      tenure_d = {cfg_wdata_i[8 + `TENURE_WR_MSB:8 + `TENURE_WR_LSB], `TENURE_RO_ZERO};
    end
    else if (boot_ok)
    begin
      // Boot load replaces the reset value, same field split (see [R5])
      tenure_d = {nv_tenure_i[`TENURE_WR_MSB:`TENURE_WR_LSB], `TENURE_RO_ZERO};
    end
  end

  // Class code: read only from the bus, boot load only if defined
  always_comb
  begin
    class_d     = class_q;
    class_rej_d = class_rej_q;
    if (boot_ok)
    begin
      // Undefined codes leave the current class code unchanged (see [R19])
      class_rej_d = !class_legal;
      if (class_legal)
      begin
        class_d = nv_class_i;       // Encodings checked by the table (see [R9])
      end
    end
  end

  // Tenure count and phase
  always_comb
  begin
    state_d = state_q;
    count_d = count_q;
    stop_d  = 1'b0;
    unique case (state_q)
      TEN_IDLE:
      begin
        // Start on our own frame while granted (see [R6])
        if (frame_start)
        begin
          count_d = tenure_q;
          state_d = TEN_RUN;
        end
      end
      TEN_RUN:
      begin
        if (!mst_frame_i)
        begin
          state_d = TEN_IDLE;       // Master finished on its own
        end
        else if (!count_zero)
        begin
          count_d = count_q - `TENURE_STEP; // One step per clock (see [R6])
        end
        else if (!granted)
        begin
          state_d = TEN_EXPIRED;    // Expired and grant gone (see [R8])
        end
        // Grant loss before expiry is ignored here (see [R7])
      end
      TEN_EXPIRED:
      begin
        // Hold stop until the master drops its frame (see [R8])
        stop_d = mst_frame_i;
        if (!mst_frame_i)
        begin
          state_d = TEN_IDLE;
        end
      end
    endcase
  end

  // Command filter: invalidate form becomes a plain memory write
  assign cmd_d = (mst_cmd_i == `CMD_MEM_WR_INV) ? `CMD_MEM_WRITE : mst_cmd_i; // see [R2]

  // Live flag taken from the next phase, so the pin leaves a flip-flop with no lag
  assign live_d = (state_d == TEN_RUN) && (count_d != `TENURE_ZERO); // see [R7]

  // Read mux; unmapped dwords read as zero
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (hit_class)
    begin
      rdata_d[31:8] = class_q;      // Bytes 09h..0Bh (see [R19])
    end
    else if (hit_line)
    begin
      // Byte 0Ch is constant zero, byte 0Dh the timer (see [R1])
      rdata_d[7:0]  = `LINE_SIZE_RESET;
      rdata_d[15:8] = tenure_q;
    end
  end

  // Grant synchroniser
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      gnt_meta_q <= 1'b1;
      gnt_n_q    <= 1'b1;
    end
    else
    begin
      gnt_meta_q <= gnt_n_i;
      gnt_n_q    <= gnt_meta_q;
    end
  end

  // Register state
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tenure_q    <= `TENURE_RESET;   // Powers up zero (see [R5])
      class_q     <= `CLASS_RESET;    // Unclassified default (see [R19])
      class_rej_q <= 1'b0;
    end
    else
    begin
      tenure_q    <= tenure_d;
      class_q     <= class_d;
      class_rej_q <= class_rej_d;
    end
  end

  // Master timing state
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_q <= TEN_IDLE;
      count_q <= `TENURE_ZERO;
      frame_q <= 1'b0;
      stop_q  <= 1'b0;
      cmd_q   <= `CMD_MEM_WRITE;
      live_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      count_q <= count_d;
      frame_q <= mst_frame_i;
      stop_q  <= stop_d;
      cmd_q   <= cmd_d;
      live_q  <= live_d;
    end
  end

  // Bus answer and target flag
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rdata_q     <= 32'h0000_0000;
      ack_q       <= 1'b0;
      line_disc_q <= 1'b0;
    end
    else
    begin
      rdata_q     <= cfg_rd_i ? rdata_d : 32'h0000_0000;
      ack_q       <= cfg_rd_i || cfg_wr_i;
      line_disc_q <= 1'b0;            // No snoop path, so no line cut (see [R3])
    end
  end

  // Outputs, all straight from flip-flops
  assign cfg_rdata_o     = rdata_q;
  assign cfg_ack_o       = ack_q;
  assign mst_cmd_o       = cmd_q;
  assign mst_stop_o      = stop_q;
  assign tenure_live_o   = live_q;
  assign tgt_line_disc_o = line_disc_q;
  assign tenure_o        = tenure_q;
  assign class_o         = class_q;
  assign class_rej_o     = class_rej_q;

  // Checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_line_read;
    cfg_rd_i && hit_line;
  endsequence

  sequence s_run_start;
    state_q == TEN_IDLE && frame_start;
  endsequence

  // Expiry step, then stop that follows the frame of the expired cycle
  sequence s_expire_stop;
    state_q == TEN_EXPIRED ##1 mst_stop_o == $past(mst_frame_i);
  endsequence

  a_line_reads_zero: assert property ( // see [R1]
    s_line_read |=> cfg_ack_o && cfg_rdata_o[7:0] == 8'h00 && cfg_rdata_o[15:8] == $past(tenure_o))
    else $error("line size byte not zero or timer byte wrong");

  a_no_invalidate: assert property ( // see [R2]
    mst_cmd_i == 4'hF |=> mst_cmd_o == 4'h7)
    else $error("invalidate command reached the bus");

  a_no_line_cut: assert property ( // see [R3]
    !tgt_line_disc_o)
    else $error("target cut a burst at a line boundary");

  a_tenure_low_zero: assert property ( // see [R4]
    wr_tenure |=> tenure_o[2:0] == 3'h0 && tenure_o[7:3] == $past(cfg_wdata_i[15:11]))
    else $error("tenure write not masked to bits 7:3");

  a_boot_tenure: assert property ( // see [R5]
    boot_ok && !wr_tenure |=> tenure_o == {$past(nv_tenure_i[7:3]), 3'h0})
    else $error("boot load of tenure value missed");

  a_count_steps: assert property ( // see [R6]
    s_run_start ##1 (mst_frame_i && tenure_q == 8'h10) [*3] |-> count_q == 8'h0E)
    else $error("tenure count does not step once per clock");

  a_live_on_start: assert property ( // see [R6]
    s_run_start ##0 (tenure_q != `TENURE_ZERO) |=> tenure_live_o)
    else $error("live flag missing after a nonzero tenure start");

  a_keep_while_live: assert property ( // see [R7]
    state_q == TEN_RUN && !count_zero && mst_frame_i |=> !mst_stop_o)
    else $error("stop raised before tenure expired");

  a_stop_on_expiry: assert property ( // see [R8]
    state_q == TEN_RUN && count_zero && !granted && mst_frame_i
      |=> s_expire_stop)
    else $error("no stop after expiry with grant withdrawn");

  a_class_guard: assert property ( // see [R19]
    boot_ok && !class_legal |=> class_o == $past(class_o) && class_rej_o)
    else $error("undefined class code accepted");

endmodule : pci_cfg_latency_class_codes

`default_nettype wire

// file: verif/cfg_host_model.sv
// Host bridge model that issues single-dword configuration requests
`timescale 1ns/100ps
`default_nettype none

module cfg_host_model
(
  input  wire logic        clk_i,   // Block clock
  input  wire logic        ack_i,   // One-cycle answer
  input  wire logic [31:0] rdata_i, // Read data, valid with the answer
  output var  logic        rd_o,    // Read request pulse
  output var  logic        wr_o,    // Write request pulse
  output var  logic [7:0]  addr_o,  // Byte address
  output var  logic [3:0]  be_o,    // Byte enables
  output var  logic [31:0] wdata_o  // Write data
);
  // Quiet bus at time zero
  initial
  begin
    rd_o    = 1'b0;
    wr_o    = 1'b0;
    addr_o  = 8'h00;
    be_o    = 4'h0;
    wdata_o = 32'h0000_0000;
  end

  // One request; answer taken one edge later, then lines carry junk
  task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] b,
                        input logic [31:0] d, output logic [31:0] q, output logic ak);
    @(posedge clk_i);
    #1;
    rd_o    = ~wr;
    wr_o    = wr;
    addr_o  = a;
    be_o    = b;
    wdata_o = d;
    @(posedge clk_i);
    #1;
    q       = rdata_i;
    ak      = ack_i;
    rd_o    = 1'b0;
    wr_o    = 1'b0;
    // Inverted leftovers so a stale value is never mistaken for live data
    addr_o  = ~a;
    be_o    = ~b;
    wdata_o = ~d;
  endtask : access
endmodule : cfg_host_model
`default_nettype wire

// file: verif/pci_cfg_latency_class_codes_tb_top.sv
// Self-checking bench for the class code, line size and tenure timer bytes
`timescale 1ns/100ps
`default_nettype none

module pci_cfg_latency_class_codes_tb_top;
  import cfg_hdr_pkg::*;

  // Defined {base, sub, last programming interface} encodings
  localparam logic [23:0] CODES [51] = '{
    24'h010000, 24'h0101FF, 24'h010200, 24'h010300, 24'h010400, 24'h018000,
    24'h020000, 24'h020100, 24'h020200, 24'h020300, 24'h028000, 24'h030001,
    24'h030100, 24'h038000, 24'h040000, 24'h040100, 24'h048000, 24'h050000,
    24'h050100, 24'h058000, 24'h060000, 24'h060100, 24'h060200, 24'h060300,
    24'h060400, 24'h060500, 24'h060600, 24'h060700, 24'h068000, 24'h070002,
    24'h070102, 24'h078000, 24'h080002, 24'h080102, 24'h080202, 24'h080301,
    24'h088000, 24'h090000, 24'h090100, 24'h090200, 24'h098000, 24'h0A0000,
    24'h0A8000, 24'h0B0000, 24'h0B0100, 24'h0B0200, 24'h0B1000, 24'h0B4000,
    24'h0C0000, 24'h0C0100, 24'h0C0200};

  logic        core_clk_i;     // Bench clock
  logic        rstn_i;         // Reset, active low
  logic        cfg_rd;         // Host read strobe
  logic        cfg_wr;         // Host write strobe
  logic [7:0]  cfg_addr;       // Host address
  logic [3:0]  cfg_be;         // Host byte enables
  logic [31:0] cfg_wdata;      // Host write data
  logic [31:0] cfg_rdata;      // Read data from the block
  logic        cfg_ack;        // Answer from the block
  logic        nv_load_i;      // Boot load pulse
  logic        nv_valid_i;     // Boot image valid
  logic [7:0]  nv_tenure_i;    // Boot timer byte
  logic [23:0] nv_class_i;     // Boot class code
  logic        gnt_n_i;        // Grant, active low
  logic        mst_frame_i;    // Master frame
  logic [3:0]  mst_cmd_i;      // Master command in
  logic [3:0]  mst_cmd_o;      // Command on the bus
  logic        mst_stop_o;     // Tenure must end
  logic        tenure_live_o;  // Count above zero
  logic        tgt_line_disc_o; // Line boundary disconnect
  logic [7:0]  tenure_o;       // Timer register
  logic [23:0] class_o;        // Class register
  logic        class_rej_o;    // Boot class refused
  int          bad_count;      // Mismatches
  int          checked;        // Comparisons

  cfg_host_model host_u (.clk_i(core_clk_i), .ack_i(cfg_ack), .rdata_i(cfg_rdata),
    .rd_o(cfg_rd), .wr_o(cfg_wr), .addr_o(cfg_addr), .be_o(cfg_be), .wdata_o(cfg_wdata));

  // Data-ok is informational only, so it is the one input tied
  pci_cfg_latency_class_codes dut_u (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .cfg_rd_i(cfg_rd), .cfg_wr_i(cfg_wr), .cfg_addr_i(cfg_addr), .cfg_be_i(cfg_be),
    .cfg_wdata_i(cfg_wdata), .cfg_rdata_o(cfg_rdata), .cfg_ack_o(cfg_ack),
    .nv_load_i(nv_load_i), .nv_valid_i(nv_valid_i), .nv_tenure_i(nv_tenure_i),
    .nv_class_i(nv_class_i), .gnt_n_i(gnt_n_i), .mst_frame_i(mst_frame_i),
    .mst_data_ok_i(1'b0), .mst_cmd_i(mst_cmd_i), .mst_cmd_o(mst_cmd_o),
    .mst_stop_o(mst_stop_o), .tenure_live_o(tenure_live_o),
    .tgt_line_disc_o(tgt_line_disc_o), .tenure_o(tenure_o), .class_o(class_o),
    .class_rej_o(class_rej_o));

  // 250 MHz clock
  initial
  begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end

  // Move just past the rising edge so every input change is clear of sampling
  task automatic step;
    @(posedge core_clk_i);
    #1;
  endtask : step

  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      $display("unexpected %s: expected %h, seen %h", n, e, g);
      bad_count++;
    end
  endtask : chk_word

  task automatic chk_flag(input string n, input logic e, input logic g);
    checked++;
    if (g !== e)
    begin
      $display("unexpected %s: expected %b, seen %b", n, e, g);
      bad_count++;
    end
  endtask : chk_flag

  // Read one dword and compare data and answer
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] q;
    logic        ak;
    host_u.access(1'b0, a, 4'hF, 32'h0000_0000, q, ak);
    chk_flag("read ack", 1'b1, ak);
    chk_word(n, e, q);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    logic [31:0] q;
    logic        ak;
    host_u.access(1'b1, a, b, d, q, ak);
    chk_flag("write ack", 1'b1, ak);
  endtask : wr

  // Boot load pulse; registers are settled when this returns
  task automatic load(input logic v, input logic [7:0] t, input logic [23:0] c);
    step;
    nv_load_i   = 1'b1;
    nv_valid_i  = v;
    nv_tenure_i = t;
    nv_class_i  = c;
    step;
    nv_load_i   = 1'b0;
    nv_tenure_i = ~t;
    nv_class_i  = ~c;
  endtask : load

  task automatic final_report;
    $display("checked %0d, bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report

  // Main sequence
  initial
  begin
    int          live_n;
    int          first;
    logic [23:0] c;
    logic        seen;
    bad_count   = 0;
    checked     = 0;
    rstn_i      = 1'b0;
    nv_load_i   = 1'b0;
    nv_valid_i  = 1'b0;
    nv_tenure_i = 8'h00;
    nv_class_i  = 24'h000000;
    gnt_n_i     = 1'b1;
    mst_frame_i = 1'b0;
    mst_cmd_i   = 4'h0;
    repeat (2) @(posedge core_clk_i);
    #1;
    rstn_i = 1'b1;
    chk_word("tenure", 32'h0, {24'h0, tenure_o});
    chk_flag("line disc", 1'b0, tgt_line_disc_o);
    rd(8'h08, 32'hFF00_0000, "class dword");
    rd(8'h0C, 32'h0000_0000, "line dword");
    $display("test reset done");
    // Only timer bits 7:3 take writes; line size byte and class ignore them
    wr(8'h0C, 4'hF, 32'hFFFF_FFFF);
    rd(8'h0C, 32'h0000_F800, "line dword");
    wr(8'h0D, 4'h2, 32'hFFFF_57FF);
    wr(8'h0C, 4'hD, 32'hFFFF_FFFF);
    rd(8'h0C, 32'h0000_5000, "line dword");
    wr(8'h08, 4'hF, 32'h1234_5678);
    rd(8'h08, 32'hFF00_0000, "class dword");
    rd(8'h40, 32'h0000_0000, "unmapped dword");
    $display("test registers done");
    // An invalid image loads nothing; a valid one loads timer and class
    load(1'b0, 8'h88, 24'h020000);
    chk_word("tenure", 32'h50, {24'h0, tenure_o});
    chk_word("class", 32'hFF0000, {8'h0, class_o});
    load(1'b1, 8'h4F, 24'h020000);
    chk_word("tenure", 32'h48, {24'h0, tenure_o});
    // Every defined encoding is kept; one step past the last interface is refused
    foreach (CODES[i])
    begin
      for (int p = 0; p <= int'(CODES[i][7:0]); p++)
      begin
        c = {CODES[i][23:8], 8'(p)};
        load(1'b1, 8'h00, c);
        chk_word("class", {8'h0, c}, {8'h0, class_o});
        chk_flag("class refused", 1'b0, class_rej_o);
      end
      if (CODES[i][7:0] != 8'hFF)
      begin
        load(1'b1, 8'h00, CODES[i] + 24'h1);
        chk_word("class", {8'h0, c}, {8'h0, class_o});
        chk_flag("class refused", 1'b1, class_rej_o);
      end
    end
    load(1'b1, 8'h00, 24'h010500);
    chk_flag("class refused", 1'b1, class_rej_o);
    load(1'b1, 8'h00, 24'h0D0000);
    chk_word("class", 32'h0C0200, {8'h0, class_o});
    rd(8'h08, 32'h0C02_0000, "class dword");
    $display("test class codes done");
    // Memory write and invalidate is replaced; every other command passes
    for (int k = 0; k < 16; k++)
    begin
      mst_cmd_i = 4'(k);
      step;
      chk_word("command", (k == 15) ? 32'h7 : 32'(k), {28'h0, mst_cmd_o});
    end
    $display("test commands done");
    // Grant withdrawn early: the bus is kept for the programmed count
    wr(8'h0C, 4'h2, 32'h0000_1000);
    gnt_n_i = 1'b0;
    repeat (3) step;
    mst_frame_i = 1'b1;
    live_n = 0;
    first  = 0;
    for (int k = 1; k <= 24; k++)
    begin
      step;
      if (k == 2)
        gnt_n_i = 1'b1;
      if (tenure_live_o === 1'b1)
        live_n++;
      if (mst_stop_o === 1'b1 && first == 0)
        first = k;
    end
    chk_word("live cycles", 32'h10, 32'(live_n));
    chk_word("stop cycle", 32'h13, 32'(first));
    chk_flag("stop held", 1'b1, mst_stop_o);
    mst_frame_i = 1'b0;
    repeat (2) step;
    chk_flag("stop", 1'b0, mst_stop_o);
    // Count runs out while granted: no stop until the grant goes
    wr(8'h0D, 4'h2, 32'h0000_0800);
    gnt_n_i = 1'b0;
    repeat (3) step;
    mst_frame_i = 1'b1;
    seen = 1'b0;
    repeat (20)
    begin
      step;
      seen = seen | (mst_stop_o !== 1'b0);
    end
    chk_flag("stop while granted", 1'b0, seen);
    gnt_n_i = 1'b1;
    repeat (6) step;
    chk_flag("stop", 1'b1, mst_stop_o);
    mst_frame_i = 1'b0;
    repeat (2) step;
    $display("test tenure done");
    final_report();
  end

  // Tests need some 850 cycles; cut a hang off well beyond that
  initial
  begin
    #100us;
    bad_count++;
    final_report();
  end
endmodule : pci_cfg_latency_class_codes_tb_top
`default_nettype wire
